//--- src/code_guard.sv
`timescale 1ns/1ps
`include "code_guard_defines.svh"
module code_guard #(
	parameter int WORDS = 8
) (
	// clock and reset
	input  wire logic        i_mclk,
	input  wire logic        i_rst_n,
	// cpu access, one-cycle strobes
	input  wire logic [21:0] i_addr,
	input  wire logic        i_rd,
	input  wire logic        i_wr,
	input  wire logic        i_fetch,
	input  wire logic        i_from_debug,
	input  wire logic [15:0] i_wdata,
	input  wire logic [21:0] i_pc,
	input  wire logic        i_protected_write_enable,
	// data returned by the memories
	input  wire logic [15:0] i_mem_rdata,
	// emulator
	input  wire logic        i_emu_attached,
	input  wire logic        i_hold_in_reset,
	input  wire logic        i_emu_ready,
	// results
	output logic [15:0]      o_rdata,
	output logic             o_mem_en,
	output logic             o_blocked,
	output logic             o_locked,
	output logic             o_emu_cut,
	output logic             o_core_hold
);
	typedef struct packed {
		code_guard_pkg::guard_state_e st;
		logic [16*WORDS-1:0]          unlock;
		logic [16*WORDS-1:0]          pwd;
		logic [WORDS-1:0]             seen;
		logic                         zero_at_reset;
		logic                         cut;
		logic [15:0]                  rdata;
	} state_s;

	state_s cur;
	state_s next_cur;
	logic   full_match;
	logic   low_match;
	logic   all_ones;
	logic   all_zero;
	logic   all_seen;

	password_match_flow #(.WORDS(WORDS)) u_match (
		.i_unlock    (cur.unlock),
		.i_pwd       (cur.pwd),
		.i_seen      (cur.seen),
		.o_full_match(full_match),
		.o_low_match (low_match),
		.o_all_ones  (all_ones),
		.o_all_zero  (all_zero),
		.o_all_seen  (all_seen)
	);

	function automatic logic in_rng(input logic [21:0] a, input logic [21:0] lo, input logic [21:0] hi);
		in_rng = (a >= lo) && (a <= hi);
	endfunction : in_rng

	// secure memory decode, used for pc and access address
	function automatic logic is_secure(input logic [21:0] a);
		is_secure = in_rng(a, `CG_FLASH_LO, `CG_FLASH_HI) || in_rng(a, `CG_OTP_LO, `CG_VOTP_HI)
			|| in_rng(a, `CG_RAM_LO, `CG_RAM_HI) || in_rng(a, `CG_RAM2_LO, `CG_RAM2_HI)
			|| in_rng(a, `CG_FCFG_LO, `CG_FCFG_HI);
	endfunction : is_secure

	// vendor otp and flash config do not trip the emulation guard
	function automatic logic trips_emu(input logic [21:0] a);
		trips_emu = in_rng(a, `CG_FLASH_LO, `CG_FLASH_HI) || in_rng(a, `CG_OTP_LO, `CG_OTP_HI)
			|| in_rng(a, `CG_RAM_LO, `CG_RAM_HI) || in_rng(a, `CG_RAM2_LO, `CG_RAM2_HI);
	endfunction : trips_emu

	logic access;
	logic sec_addr;
	logic pc_sec;
	logic locked;
	logic allow;
	logic unlock_hit;
	logic ctrl_hit;
	logic pwd_hit;
	logic [2:0] widx;
	logic pwd_rd;

	always_comb begin
		access     = i_rd | i_wr | i_fetch;
		sec_addr   = is_secure(i_addr);
		pc_sec     = is_secure(i_pc);
		locked     = (cur.st != code_guard_pkg::ST_OPEN);
		unlock_hit = in_rng(i_addr, `CG_UNLOCK_BASE, `CG_UNLOCK_LAST);
		ctrl_hit   = (i_addr == `CG_CTRL_ADDR);
		pwd_hit    = in_rng(i_addr, `CG_PWD_BASE, `CG_PWD_LAST);
		widx       = i_addr[2:0];
		allow      = 1'b1;
		if (locked && sec_addr) begin
			if (i_from_debug) begin
				// debug port always blocked from secure memory while locked
				allow = 1'b0;
			end else if (!pc_sec && !i_fetch) begin
				// data access from nonsecure code blocked
				allow = 1'b0;
			end
		end
		pwd_rd = i_rd && pwd_hit && !i_from_debug;
	end

	assign o_mem_en    = access && allow && !o_core_hold;
	assign o_blocked   = access && !allow;
	assign o_locked    = locked;
	assign o_emu_cut   = cur.cut;
	assign o_rdata     = cur.rdata;
	// core held while emulator takes control
	assign o_core_hold = (cur.st == code_guard_pkg::ST_RESET_HOLD);

	always_comb begin
		next_cur = cur;
		next_cur.rdata = 16'h0000;
		case (cur.st)
			code_guard_pkg::ST_RESET_HOLD: begin
				if (!i_hold_in_reset || i_emu_ready) begin
					next_cur.st = code_guard_pkg::ST_LOCKED;
				end
			end
			code_guard_pkg::ST_LOCKED: begin
				// all-ones password opens once read, zero never opens
				// full compare after every word seen
				if (all_seen && !all_zero && !cur.zero_at_reset && (all_ones || full_match)) begin
					next_cur.st = code_guard_pkg::ST_OPEN;
				end
			end
			code_guard_pkg::ST_OPEN: begin
			end
			default: next_cur.st = code_guard_pkg::ST_LOCKED;
		endcase
		// password words captured by software reads of the top of flash
		if (pwd_rd) begin
			next_cur.pwd[16*widx +: 16] = i_mem_rdata;
			next_cur.seen[widx]         = 1'b1;
			if (widx == 3'h0) begin
				next_cur.zero_at_reset = 1'b0;
			end
		end
		if (i_rd && allow && !unlock_hit && !ctrl_hit) begin
			next_cur.rdata = i_mem_rdata;
		end else if (i_rd && ctrl_hit) begin
			next_cur.rdata = `CG_CTRL_RSV | {15'h0000, locked};
		end else if (i_rd && unlock_hit) begin
			next_cur.rdata = cur.unlock[16*widx +: 16];
		end
		// blocked reads give zero without stall
		if (i_wr && unlock_hit && i_protected_write_enable) begin
			next_cur.unlock[16*widx +: 16] = i_wdata;
		end
		if (i_wr && ctrl_hit && i_protected_write_enable && i_wdata[`CG_FORCE_BIT]) begin
			next_cur.unlock = {WORDS{`CG_WORD_RESET}};
			next_cur.st     = code_guard_pkg::ST_LOCKED;
			// fresh password reads needed, else an all-ones password would reopen at once
			next_cur.seen   = '0;
		end
		if (i_emu_attached && access && trips_emu(i_addr) && !(all_seen && (all_ones || low_match))) begin
			next_cur.cut = 1'b1;
		end
		if (!i_emu_attached) begin
			next_cur.cut = 1'b0;
		end
	end

	// reset to ST_RESET_HOLD (locked) with unlock words at all ones
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cur.st            <= code_guard_pkg::ST_RESET_HOLD;
			cur.unlock        <= {WORDS{16'hFFFF}};
			cur.pwd           <= '0;
			cur.seen          <= '0;
			cur.zero_at_reset <= 1'b0;
			cur.cut           <= 1'b0;
			cur.rdata         <= 16'h0000;
		end else begin
			cur <= next_cur;
		end
	end

	blocked_read_zero_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(i_rd && !allow) |=> (o_rdata == 16'h0000)) else $error("blocked read returned data");
	debug_blocked_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(o_locked && i_from_debug && sec_addr && access) |-> !o_mem_en) else $error("debug reached secure memory");
	fetch_allowed_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(i_fetch && !i_from_debug && !o_core_hold) |-> o_mem_en) else $error("fetch refused");
	open_full_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(!o_locked && access) |-> !o_blocked) else $error("open device blocked access");
	zero_stays_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(o_locked && all_zero && !pwd_rd) |=> o_locked) else $error("zero password unlocked");
	unlock_cause_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		($fell(o_locked)) |-> $past(all_seen)) else $error("unlock without match flow");
	relock_force_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(i_wr && ctrl_hit && i_protected_write_enable && i_wdata[15]) |=> (o_locked && &cur.unlock))
		else $error("force relock failed");
	key_guard_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(i_wr && unlock_hit && !i_protected_write_enable) |=> $stable(cur.unlock)) else $error("unprotected write");
	emu_trip_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(i_emu_attached && access && trips_emu(i_addr) && !all_seen) |=> o_emu_cut) else $error("guard not tripped");
	hold_reset_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(o_core_hold && i_hold_in_reset && !i_emu_ready) |=> o_core_hold) else $error("hold released early");
endmodule : code_guard

//--- src/code_guard_defines.svh
`ifndef CODE_GUARD_DEFINES_SVH
`define CODE_GUARD_DEFINES_SVH
// What this block does
// - blocked reads return zero and never stall the processor
// - locked, fetch inside secure memory: only debug port accesses blocked
// - locked, fetch outside: data blocked, instruction fetches still allowed
// - lock decision re-evaluated every access from current fetch location
// - unlocked: processor and debug port have full access
// - password is 128 bits as eight 16-bit words at top of flash
// - password words taken from the fixed top-of-flash address range
// - all-ones password unlocks once every password word has been read
// - all-zeros password keeps device locked whatever the unlock words hold
// - reset with all-zero password: match flow never unlocks
// - only a correct password match flow clears the locked state
// - eight unlock words at consecutive addresses, writes need protected enable
// - emulator attached, secure access other than vendor OTP and flash config trips the emulation guard, cuts debug
// - lower 64 bits matching disarms emulation guard, read protection stays
// - all-ones password read back needs no match for the emulation guard
// - hold-in-reset emulation mode keeps device in reset until emulator ready
// - writing one to force-relock bit 15 sets unlock words to all ones and locks
// - unlock words reset to all ones
// - vendor OTP accesses do not trip the emulation guard but are protected

`define CG_UNLOCK_BASE   22'h000AE0
`define CG_UNLOCK_LAST   22'h000AE7
`define CG_CTRL_ADDR     22'h000AEF
`define CG_PWD_BASE      22'h3F7FF8
`define CG_PWD_LAST      22'h3F7FFF
`define CG_FLASH_LO      22'h3F0000
`define CG_FLASH_HI      22'h3F7FFF
`define CG_OTP_LO        22'h3D7800
`define CG_OTP_HI        22'h3D7BFF
`define CG_VOTP_LO       22'h3D7C00
`define CG_VOTP_HI       22'h3D7FFF
`define CG_RAM_LO        22'h008000
`define CG_RAM_HI        22'h008FFF
`define CG_RAM2_LO       22'h3F8000
`define CG_RAM2_HI       22'h3F8FFF
`define CG_FCFG_LO       22'h000A80
`define CG_FCFG_HI       22'h000A87
`define CG_FORCE_BIT     15
`define CG_WORD_RESET    16'hFFFF
`define CG_CTRL_RSV      16'h002E
`endif

//--- src/code_guard_pkg.sv
package code_guard_pkg;
	typedef enum logic [1:0] {
		ST_RESET_HOLD,
		ST_LOCKED,
		ST_OPEN
	} guard_state_e;
	typedef logic [15:0] word_t;
	typedef logic [21:0] addr_t;
endpackage : code_guard_pkg

//--- src/password_match_flow.sv
`timescale 1ns/1ps
`include "code_guard_defines.svh"
module password_match_flow #(
	parameter int WORDS = 8
) (
	// unlock words and password words
	input  wire logic [16*WORDS-1:0] i_unlock,
	input  wire logic [16*WORDS-1:0] i_pwd,
	input  wire logic [WORDS-1:0]    i_seen,
	// verdicts
	output logic                     o_full_match,
	output logic                     o_low_match,
	output logic                     o_all_ones,
	output logic                     o_all_zero,
	output logic                     o_all_seen
);
	assign o_full_match = (i_unlock == i_pwd);
	assign o_low_match  = (i_unlock[8*WORDS-1:0] == i_pwd[8*WORDS-1:0]);
	assign o_all_ones   = &i_pwd;
	assign o_all_zero   = ~|i_pwd;
	assign o_all_seen   = &i_seen;
endmodule : password_match_flow

//--- tb/code_guard_test.sv
`timescale 1ns/1ps
`include "code_guard_defines.svh"
module code_guard_test;
	logic i_mclk, i_rst_n, i_rd, i_wr, i_fetch, i_from_debug, i_protected_write_enable;
	logic i_emu_attached, i_hold_in_reset, i_emu_ready, o_mem_en, o_blocked, o_locked, o_emu_cut, o_core_hold;
	logic [21:0] i_addr, i_pc;
	logic [15:0] i_wdata, i_mem_rdata, o_rdata, rd_s;
	logic [127:0] pwd;
	logic en_s, blk_s;
	int n_errors, num_checks, cyc;
	localparam logic [127:0] P = 128'h1357_2468_ACE0_BDF1_0F1E_2D3C_4B5A_6978;
	localparam logic [21:0] FL = 22'h3F1234;
	code_guard dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_rd(i_rd), .i_wr(i_wr),
		.i_fetch(i_fetch), .i_from_debug(i_from_debug), .i_wdata(i_wdata), .i_pc(i_pc),
		.i_protected_write_enable(i_protected_write_enable), .i_mem_rdata(i_mem_rdata),
		.i_emu_attached(i_emu_attached), .i_hold_in_reset(i_hold_in_reset), .i_emu_ready(i_emu_ready),
		.o_rdata(o_rdata), .o_mem_en(o_mem_en), .o_blocked(o_blocked), .o_locked(o_locked),
		.o_emu_cut(o_emu_cut), .o_core_hold(o_core_hold));
	mem_model mem (.i_addr(i_addr), .i_pwd(pwd), .o_rdata(i_mem_rdata));
	initial begin
		i_mclk = 0;
		forever #2.5 i_mclk = ~i_mclk;
	end
	task wrap_up;
		$display("errors=%0d checks=%0d", n_errors, num_checks);
		if (n_errors == 0 && num_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : wrap_up
	always @(posedge i_mclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_errors++;
			wrap_up();
		end
	end
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	// k = {debug, fetch, write, read}
	task acc(input logic [21:0] a, input logic [3:0] k, input logic [15:0] d);
		@(posedge i_mclk);
		i_addr <= a;
		{i_from_debug, i_fetch, i_wr, i_rd} <= k;
		i_wdata <= d;
		@(negedge i_mclk);
		en_s = o_mem_en;
		blk_s = o_blocked;
		@(posedge i_mclk);
		{i_from_debug, i_fetch, i_wr, i_rd} <= 4'h0;
		@(negedge i_mclk);
		rd_s = o_rdata;
	endtask : acc
	task settle;
		repeat (2) @(posedge i_mclk);
		@(negedge i_mclk);
	endtask : settle
	task rst(input logic [127:0] p);
		@(posedge i_mclk);
		i_rst_n <= 0;
		pwd <= p;
		i_pc <= `CG_FLASH_LO;
		repeat (16) @(posedge i_mclk);
		i_rst_n <= 1;
		settle();
	endtask : rst
	task rd_pwd;
		for (int i = 0; i < 8; i++) acc(`CG_PWD_BASE + 22'(i), 4'h1, 16'h0000);
		settle();
	endtask : rd_pwd
	task keys(input logic [127:0] k, input int n);
		for (int i = 0; i < n; i++) acc(`CG_UNLOCK_BASE + 22'(i), 4'h2, k[16*i +: 16]);
		settle();
	endtask : keys
	task t_locked;
		rst(P);
		chk(16'(o_locked), 16'h0001);
		acc(`CG_CTRL_ADDR, 4'h1, 16'h0000);
		chk(rd_s, 16'h002F);
		acc(`CG_UNLOCK_BASE + 22'h000003, 4'h1, 16'h0000);
		chk(rd_s, 16'hFFFF);
		i_pc <= 22'h000100;
		acc(FL, 4'h1, 16'h0000);
		chk({15'h0, blk_s}, 16'h0001);
		chk(rd_s, 16'h0000);
		acc(FL, 4'h4, 16'h0000);
		chk({15'h0, en_s}, 16'h0001);
		i_pc <= `CG_FLASH_LO;
		acc(FL, 4'h1, 16'h0000);
		chk(rd_s, ~FL[15:0] ^ 16'h5A5A);
		acc(FL, 4'h9, 16'h0000);
		chk({15'h0, blk_s}, 16'h0001);
	endtask : t_locked
	task t_unlock;
		rd_pwd();
		keys(P, 8);
		chk(16'(o_locked), 16'h0001);
		i_protected_write_enable <= 1;
		keys(P, 8);
		chk(16'(o_locked), 16'h0000);
		i_pc <= 22'h000100;
		acc(FL, 4'h9, 16'h0000);
		chk(rd_s, ~FL[15:0] ^ 16'h5A5A);
		acc(`CG_CTRL_ADDR, 4'h2, 16'h8000);
		settle();
		chk(16'(o_locked), 16'h0001);
		i_protected_write_enable <= 0;
	endtask : t_unlock
	task t_pwd_kinds;
		rst({128{1'b1}});
		rd_pwd();
		chk(16'(o_locked), 16'h0000);
		i_emu_attached <= 1;
		acc(FL, 4'h1, 16'h0000);
		settle();
		chk(16'(o_emu_cut), 16'h0000);
		i_emu_attached <= 0;
		// all-zero password is the one case the programmer must never set
		rst(128'h0);
		rd_pwd();
		i_protected_write_enable <= 1;
		keys(128'h0, 8);
		chk(16'(o_locked), 16'h0001);
	endtask : t_pwd_kinds
	task t_emu;
		rst(P);
		rd_pwd();
		i_emu_attached <= 1;
		acc(`CG_VOTP_LO, 4'h1, 16'h0000);
		settle();
		chk(16'(o_emu_cut), 16'h0000);
		acc(FL, 4'h1, 16'h0000);
		settle();
		chk(16'(o_emu_cut), 16'h0001);
		i_emu_attached <= 0;
		i_protected_write_enable <= 1;
		keys(P, 4);
		i_emu_attached <= 1;
		i_pc <= 22'h000100;
		acc(FL, 4'h1, 16'h0000);
		chk({15'h0, blk_s}, 16'h0001);
		settle();
		chk(16'(o_emu_cut), 16'h0000);
		i_emu_attached <= 0;
		i_protected_write_enable <= 0;
	endtask : t_emu
	task t_hold;
		i_hold_in_reset <= 1;
		rst(P);
		chk(16'(o_core_hold), 16'h0001);
		i_emu_ready <= 1;
		settle();
		chk(16'(o_core_hold), 16'h0000);
	endtask : t_hold
	initial begin
		{i_rst_n, i_rd, i_wr, i_fetch, i_from_debug, i_protected_write_enable} = 6'h0;
		{i_emu_attached, i_hold_in_reset, i_emu_ready} = 3'h0;
		{i_addr, i_pc, i_wdata, pwd} = '0;
		{n_errors, num_checks, cyc} = '0;
		t_locked();
		t_unlock();
		t_pwd_kinds();
		t_emu();
		t_hold();
		wrap_up();
	end
endmodule : code_guard_test

//--- tb/mem_model.sv
`timescale 1ns/1ps
`include "code_guard_defines.svh"
module mem_model (
	// access address and programmed password
	input  wire logic [21:0]  i_addr,
	input  wire logic [127:0] i_pwd,
	// combinational read data
	output logic [15:0]       o_rdata
);
	always_comb begin
		if (i_addr >= `CG_PWD_BASE && i_addr <= `CG_PWD_LAST) begin
			o_rdata = i_pwd[16*i_addr[2:0] +: 16];
		end else if (i_addr >= 22'h3F7F80 && i_addr <= 22'h3F7FF5) begin
			o_rdata = 16'h0000;
		end else begin
			// per-address pattern so a stale value never looks right
			o_rdata = ~i_addr[15:0] ^ 16'h5A5A;
		end
	end
endmodule : mem_model
